// ===== inc/sldf_pkg.sv
// Constants and types shared by the serial loop DAC front end.
// Assumes a single system clock; all link pins are sampled on it.
package sldf_pkg;
  // Code word and framed-mode bit timing, counted in link clocks
  localparam int WORD_W = 16;
  localparam int CELL_CLKS = 16;
  localparam int START_CHECK = 8;
  localparam int FIRST_SAMPLE = 24;
  localparam int STOP_SAMPLE = FIRST_SAMPLE + WORD_W * CELL_CLKS;
  localparam int CNT_W = 9;
  // Link clocks with the load line high before framed mode is taken
  localparam int MODE_EDGES = 16;
  localparam int MODE_W = 5;
  localparam logic [WORD_W-1:0] CODE_RESET = 16'h0000;
  // Modulator update divider and integrator width
  localparam int MOD_DIV = 4;
  localparam int INT_W = 24;
  // Bit positions of the synchronised pin vector
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDIN = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_CLR = 3;
  localparam int PIN_FLT = 4;
  localparam int PIN_N = 5;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b11
  } sldf_rx_state_t;
endpackage

// ===== inc/sldf_rx_if.sv
// Carrier between the front end core and its framed-word receiver.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface sldf_rx_if;
  import sldf_pkg::*;
  logic en;
  logic tick;
  logic din;
  logic load;
  logic err;
  logic [WORD_W-1:0] word;
  modport rx (input en, input tick, input din, output load, output err, output word);
  modport core (output en, output tick, output din, input load, input err, input word);
endinterface

// ===== rtl/sldf_async_rx.sv
// Framed asynchronous word receiver of the serial loop DAC front end.
// Assumes tick is a one-cycle pulse per rising link clock edge and din
// is already synchronised.
`timescale 1ns/100ps
module sldf_async_rx (
  input wire logic clock,
  input wire logic rstn,
  sldf_rx_if.rx bus
);
  import sldf_pkg::*;
  localparam logic [CNT_W-1:0] C_CHK = CNT_W'(START_CHECK);
  localparam logic [CNT_W-1:0] C_FIRST = CNT_W'(FIRST_SAMPLE);
  localparam logic [CNT_W-1:0] C_STOP = CNT_W'(STOP_SAMPLE);
  localparam logic [3:0] PHASE = 4'(FIRST_SAMPLE % CELL_CLKS);
  sldf_rx_state_t st, next_st;
  logic [CNT_W-1:0] cnt, next_cnt, cnt_n;
  logic [WORD_W-1:0] sh, next_sh;
  logic load, next_load, err, next_err;

  // Clock zero is the first tick that sees the start bit low
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_load = 1'b0;
    next_err = err;
    cnt_n = cnt + 1'b1;
    if (bus.tick) begin
      next_err = 1'b0; // error lasts one link clock period
    end
    if (!bus.en) begin
      next_st = RX_IDLE;
      next_err = 1'b0;
    end else if (bus.tick) begin
      case (st)
        RX_IDLE: begin
          if (!bus.din) begin
            next_st = RX_START;
            next_cnt = '0;
          end
        end
        RX_START: begin
          next_cnt = cnt_n;
          // Mid-cell recheck rejects glitches on an idle line
          if (cnt_n == C_CHK) begin
            next_st = bus.din ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          next_cnt = cnt_n;
          if (cnt_n == C_STOP) begin
            next_st = RX_IDLE;
            if (bus.din) begin
              next_load = 1'b1; // good frame makes the load strobe
            end else begin
              next_err = 1'b1; // bad stop bit: flag, no update
            end
          end else if (cnt_n >= C_FIRST && cnt_n[3:0] == PHASE) begin
            next_sh = {sh[WORD_W-2:0], bus.din}; // MSB at 24, then every 16
          end
        end
        default: next_st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= RX_IDLE;
      cnt <= '0;
      sh <= '0;
      load <= 1'b0;
      err <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      load <= next_load;
      err <= next_err;
    end
  end

  assign bus.load = load;
  assign bus.err = err;
  assign bus.word = sh;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_stop_bad;
    bus.en && bus.tick && st == RX_BITS && cnt_n == C_STOP && !bus.din;
  endsequence
  sequence s_next_tick;
    ##[0:200] bus.tick;
  endsequence
  property p_msb_sample;
    bus.en && bus.tick && st == RX_BITS && cnt_n == C_FIRST |=> sh[0] == $past(bus.din);
  endproperty
  a_msb_sample: assert property (p_msb_sample) else $error("MSB not taken at clock 24");
  property p_err_pulse;
    s_stop_bad |=> (err throughout s_next_tick) ##1 !err;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("Framing error pulse wrong");
  property p_no_update;
    s_stop_bad |=> !load;
  endproperty
  a_no_update: assert property (p_no_update) else $error("Bad frame loaded a code");
endmodule

// ===== rtl/sldf_mod2.sv
// Second-order one-bit modulator of the serial loop DAC front end.
// Assumes code is a registered straight binary value on the same clock.
`timescale 1ns/100ps
module sldf_mod2 #(
  parameter int DIV = sldf_pkg::MOD_DIV,
  parameter int IW = sldf_pkg::INT_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [sldf_pkg::WORD_W-1:0] code,
  output logic pdm
);
  import sldf_pkg::*;
  localparam logic signed [IW+1:0] FB = (IW+2)'(1 << WORD_W);
  localparam logic signed [IW+1:0] LIM = (IW+2)'(1 << (IW - 2));
  logic [7:0] div, next_div;
  logic en;
  logic signed [IW-1:0] i1, i2, next_i1, next_i2;
  logic next_pdm;
  logic signed [IW+1:0] x, fb;

  // Saturation keeps a large step from wrapping an integrator
  function automatic logic signed [IW-1:0] sat(input logic signed [IW+1:0] v);
    if (v > LIM) begin
      return IW'(LIM);
    end else if (v < -LIM) begin
      return IW'(-LIM);
    end
    return IW'(v);
  endfunction

  // Update enable from the divider, then two integrators in cascade
  always_comb begin
    next_div = div;
    en = (div == 8'(DIV - 1));
    next_div = en ? 8'h00 : div + 8'h01;
    x = $signed({{(IW+2-WORD_W){1'b0}}, code});
    fb = pdm ? FB : '0;
    next_i1 = i1;
    next_i2 = i2;
    next_pdm = pdm;
    if (code == CODE_RESET) begin
      // Idle at zero so the bottom of range has no stray pulses
      next_i1 = '0;
      next_i2 = '0;
      next_pdm = 1'b0;
    end else if (en) begin
      next_i1 = sat((IW+2)'(i1) + x - fb);
      next_i2 = sat((IW+2)'(i2) + (IW+2)'(next_i1) - fb);
      next_pdm = (next_i2 > 0);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div <= 8'h00;
      i1 <= '0;
      i2 <= '0;
      pdm <= 1'b0;
    end else begin
      div <= next_div;
      i1 <= next_i1;
      i2 <= next_i2;
      pdm <= next_pdm;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_zero_code;
    code == CODE_RESET |=> !pdm;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("Zero code gave a pulse");
  property p_pdm_en;
    !en && code != CODE_RESET |=> $stable(pdm);
  endproperty
  a_pdm_en: assert property (p_pdm_en) else $error("Bit stream moved off enable");
endmodule

// ===== rtl/sldf_top.sv
// Digital front end of a 16-bit current-loop DAC: serial input,
// holding latch, open-drain loop fault and one-bit modulator.
// Assumes every pin input is asynchronous to clock; the link clock
// is sampled, not used as a clock.
`timescale 1ns/100ps
// Summary of operation
// - Three-wire: shift one data bit per clock
// - Load strobe moves shift register to latch
// - Serial output passes data down the chain
// - Load held high selects framed mode
// - Framed word with stop bit loads latch
// - Framing error gives pulse on serial output
// - Second-order modulator makes one-bit stream
// - Loop fault is open-drain active low
// - Latch holds a sixteen bit code
// - Straight binary, zero is range bottom
// - Sixteen clocks per cell, MSB at 24
// - Bad stop: no update, one-clock pulse
// - Clear forces minimum, input register kept
// - Three-wire transfer on load rising edge
module sldf_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic latch,
  input wire logic clear,
  input wire logic loop_fault,
  output logic sdout,
  output logic fault_n_o,
  output logic fault_n_oe,
  output logic pdm_out,
  output logic [sldf_pkg::WORD_W-1:0] dac_code,
  output logic async_mode
);
  import sldf_pkg::*;

  logic [PIN_N-1:0] meta, next_meta;
  logic [PIN_N-1:0] pins, next_pins;
  logic sclk_d, next_sclk_d;
  logic latch_d, next_latch_d;
  logic tick, latch_rise;
  logic sclk_s, din_s, latch_s, clear_s, fault_s;
  logic [MODE_W-1:0] mode_cnt, next_mode_cnt;
  logic next_async;
  logic [WORD_W-1:0] sreg, next_sreg;
  logic [WORD_W-1:0] code, next_code;
  logic next_sdout;
  logic next_fault_oe;

  sldf_rx_if rx ();

  // Two-stage synchronisers; the first stage feeds only the second
  always_comb begin
    next_meta = {loop_fault, clear, latch, sdin, sclk};
    next_pins = meta;
    next_sclk_d = pins[PIN_SCLK];
    next_latch_d = pins[PIN_LOAD];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      pins <= '0;
      sclk_d <= 1'b0;
      latch_d <= 1'b0;
    end else begin
      meta <= next_meta;
      pins <= next_pins;
      sclk_d <= next_sclk_d;
      latch_d <= next_latch_d;
    end
  end

  // Clean pin levels and one-cycle edge pulses
  assign sclk_s = pins[PIN_SCLK];
  assign din_s = pins[PIN_SDIN];
  assign latch_s = pins[PIN_LOAD];
  assign clear_s = pins[PIN_CLR];
  assign fault_s = pins[PIN_FLT];
  assign tick = sclk_s & ~sclk_d;
  assign latch_rise = latch_s & ~latch_d;

  // Mode: framed only after the load line stays high across many
  // link clocks; a three-wire host never clocks with load high
  always_comb begin
    next_mode_cnt = mode_cnt;
    if (!latch_s) begin
      next_mode_cnt = '0; // any low on the load line means three-wire
    end else if (tick && mode_cnt != MODE_W'(MODE_EDGES)) begin
      next_mode_cnt = mode_cnt + 1'b1;
    end
    next_async = latch_s && (next_mode_cnt == MODE_W'(MODE_EDGES));
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_cnt <= '0;
      async_mode <= 1'b0;
    end else begin
      mode_cnt <= next_mode_cnt;
      async_mode <= next_async;
    end
  end

  // Input shift register; clear leaves it alone
  always_comb begin
    next_sreg = sreg;
    if (tick && !async_mode) begin
      next_sreg = {sreg[WORD_W-2:0], din_s}; // one bit per link clock
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sreg <= '0;
    end else begin
      sreg <= next_sreg;
    end
  end

  // Holding latch; clear wins over any load in the same cycle
  always_comb begin
    next_code = code;
    if (clear_s) begin
      next_code = CODE_RESET; // force range minimum and keep it
    end else if (!async_mode && latch_rise) begin
      next_code = sreg; // parallel load on load-line rise
    end else if (async_mode && rx.load) begin
      next_code = rx.word; // good frame updates the latch
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      code <= CODE_RESET;
    end else begin
      code <= next_code; // full sixteen bit code held
    end
  end

  // Serial output is the chain bit or, in framed mode, the error flag.
  // It lags the shift by one system clock, far inside a link period.
  always_comb begin
    if (async_mode) begin
      next_sdout = rx.err; // framing error pulse
    end else begin
      next_sdout = sreg[WORD_W-1]; // bit leaving the MSB stage
    end
    next_fault_oe = fault_s; // pull the shared line low on fault
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdout <= 1'b0;
      fault_n_oe <= 1'b0;
    end else begin
      sdout <= next_sdout;
      fault_n_oe <= next_fault_oe;
    end
  end

  // Open-drain: only ever drives low, a pull-up gives the high
  assign fault_n_o = 1'b0;
  assign dac_code = code;

  // Receiver only listens while framed mode is selected
  assign rx.en = async_mode;
  assign rx.tick = tick;
  assign rx.din = din_s;

  sldf_async_rx u_rx (
    .clock(clock),
    .rstn(rstn),
    .bus(rx)
  );

  sldf_mod2 #(
    .DIV(MOD_DIV),
    .IW(INT_W)
  ) u_mod (
    .clock(clock),
    .rstn(rstn),
    .code(code),
    .pdm(pdm_out)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_shift;
    tick && !async_mode;
  endsequence
  sequence s_latch;
    !async_mode && latch_rise && !clear_s;
  endsequence

  property p_shift;
    s_shift |=> sreg[0] == $past(din_s) && sreg[WORD_W-1:1] == $past(sreg[WORD_W-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("Shift register missed a bit");

  property p_idle_shift;
    !tick |=> $stable(sreg);
  endproperty
  a_idle_shift: assert property (p_idle_shift) else $error("Shift without clock edge");

  property p_chain;
    !async_mode ##1 !async_mode |-> sdout == $past(sreg[WORD_W-1]);
  endproperty
  a_chain: assert property (p_chain) else $error("Chain output not MSB stage");

  property p_latch;
    s_latch |=> code == $past(sreg);
  endproperty
  a_latch: assert property (p_latch) else $error("Latch not loaded on rise");

  property p_mode_low;
    !latch_s |=> !async_mode;
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("Framed mode with load low");

  property p_mode_rise;
    $rose(async_mode) |-> latch_s && $past(latch_s);
  endproperty
  a_mode_rise: assert property (p_mode_rise) else $error("Framed mode too early");

  property p_frame_load;
    async_mode && rx.load && !clear_s |=> code == $past(rx.word);
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("Framed word not loaded");

  property p_err_out;
    async_mode && rx.err ##1 async_mode |-> sdout;
  endproperty
  a_err_out: assert property (p_err_out) else $error("Error pulse not on output");

  property p_clear;
    clear_s |=> code == CODE_RESET;
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not force minimum");

  property p_hold;
    !clear_s && !latch_rise && !rx.load |=> $stable(code);
  endproperty
  a_hold: assert property (p_hold) else $error("Code changed with no cause");

  property p_fault;
    fault_s |=> fault_n_oe && !fault_n_o;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault not driven low");

  property p_fault_off;
    !fault_s |=> !fault_n_oe;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("Fault line held without fault");

  property p_quiet_rx;
    !async_mode |=> !rx.load && !rx.err;
  endproperty
  a_quiet_rx: assert property (p_quiet_rx) else $error("Receiver active in three-wire");

  property p_framed_keep;
    async_mode |=> $stable(sreg);
  endproperty
  a_framed_keep: assert property (p_framed_keep) else $error("Shift in framed mode");

  property p_err_quiet;
    async_mode && !rx.err ##1 async_mode |-> !sdout;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("Stray error pulse");

  property p_chain_hold;
    !async_mode && !tick ##1 !async_mode |=> $stable(sdout);
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("Chain output moved idle");

  property p_load_keep;
    !async_mode && latch_rise && !tick |=> $stable(sreg);
  endproperty
  a_load_keep: assert property (p_load_keep) else $error("Load disturbed shift");

  property p_mode_need;
    !async_mode && !tick |=> !async_mode;
  endproperty
  a_mode_need: assert property (p_mode_need) else $error("Framed mode off a clock");

  property p_err_no_load;
    rx.err |-> !rx.load;
  endproperty
  a_err_no_load: assert property (p_err_no_load) else $error("Load during error");

  property p_clear_keep;
    $fell(clear_s) && !latch_rise && !rx.load |=> code == CODE_RESET;
  endproperty
  a_clear_keep: assert property (p_clear_keep) else $error("Minimum lost after clear");

  property p_async_code;
    async_mode && !rx.load && !clear_s |=> $stable(code);
  endproperty
  a_async_code: assert property (p_async_code) else $error("Framed code moved");
endmodule

// ===== verification/sldf_host_model.sv
// Host model for the serial link of the loop DAC front end.
// Assumes each task is entered at a falling edge of the system clock.
`timescale 1ns/100ps
module sldf_host_model (
  input wire logic clock,
  output logic sclk,
  output logic sdin,
  output logic latch
);
  // Link clock stands low between bits and frames; data line idles high
  initial begin
    sclk = 1'b0;
    sdin = 1'b1;
    latch = 1'b0;
  end

  // One 800 ns link period: data set 400 ns before the rise, held 400 ns after
  task automatic tick(input logic d);
    sdin = d;
    repeat (4) @(negedge clock);
    sclk = 1'b1;
    repeat (4) @(negedge clock);
    sclk = 1'b0;
  endtask

  // Load strobe; data line is released, so it shows the inverse of its last bit
  task automatic load_pulse();
    sdin = ~sdin;
    latch = 1'b1;
    repeat (6) @(negedge clock);
    latch = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // Load line held high with the link clock running selects framed mode
  task automatic set_framed(input logic on);
    latch = on;
    if (on) begin
      repeat (16) tick(1'b1);
    end else begin
      repeat (4) @(negedge clock);
    end
  endtask

  // Start cell, sixteen data cells MSB first, stop cell, then idle ones so a
  // low stop cannot be mistaken for the next start
  task automatic frame(input logic [15:0] w, input logic stop);
    logic [17:0] cells;
    cells = {1'b0, w, stop};
    for (int c = 17; c >= 0; c--) begin
      repeat (16) tick(cells[c]);
    end
    repeat (16) tick(1'b1);
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the serial loop DAC front end.
// Assumes the host model drives the link pins; bench drives the rest.
`timescale 1ns/100ps
module tb;
  import sldf_pkg::*;
  logic clock, rstn, clear, loop_fault, sclk, sdin, latch;
  logic sdout, fault_n_o, fault_n_oe, pdm_out, async_mode;
  logic [WORD_W-1:0] dac_code, exp, code, word;
  logic [31:0] rng = 32'h0000_0041;
  logic [15:0] mod_codes [3] = '{16'h0000, 16'h4000, 16'hc000};
  int n_errors = 0;
  int checks = 0;
  int hi_run = 0;
  int hi_len = 0;
  int pulses = 0;
  int p0, ones;

  sldf_top uut (.clock(clock), .rstn(rstn), .sclk(sclk), .sdin(sdin), .latch(latch),
    .clear(clear), .loop_fault(loop_fault), .sdout(sdout), .fault_n_o(fault_n_o),
    .fault_n_oe(fault_n_oe), .pdm_out(pdm_out), .dac_code(dac_code),
    .async_mode(async_mode));
  sldf_host_model host (.clock(clock), .sclk(sclk), .sdin(sdin), .latch(latch));

  // Xorshift source; a fixed start keeps runs repeatable
  function automatic logic [15:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction

  // Ones expected in 1024 clocks; code zero must leave the stream idle
  function automatic logic near(input int n, input logic [15:0] c);
    int want;
    want = (int'(c) * 1024) / 65536;
    if (c == 16'h0000) begin
      return n == 0;
    end
    return (n > want - 48) && (n < want + 48);
  endfunction

  task automatic check_eq(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Three-wire word with the serial output followed bit by bit
  task automatic load_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      repeat (2) @(negedge clock);
      check_eq(sdout, exp[15]);
      host.tick(w[i]);
      exp = {exp[14:0], w[i]};
    end
    repeat (2) @(negedge clock);
    check_eq(sdout, exp[15]);
    check_eq(dac_code, code);
    host.load_pulse();
    code = exp;
    check_eq(dac_code, code);
  endtask

  // Length and count of high runs on the serial output
  always @(negedge clock) begin
    if (sdout === 1'b1) begin
      hi_run <= hi_run + 1;
    end else if (hi_run != 0) begin
      hi_len <= hi_run;
      pulses <= pulses + 1;
      hi_run <= 0;
    end
  end

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Sized from about 12000 clocks of planned traffic
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    clear = 1'b0;
    loop_fault = 1'b0;
    exp = 16'h0000;
    code = 16'h0000;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    check_eq({sdout, async_mode, dac_code}, 18'h00000);
    // Back-to-back words, with an all-zero and an all-one boundary
    load_word(16'hffff);
    load_word(16'h0000);
    repeat (3) load_word(rnd());
    // Clear beats a load, keeps the output at zero, spares the input register
    clear = 1'b1;
    host.load_pulse();
    check_eq(dac_code, 16'h0000);
    clear = 1'b0;
    repeat (4) @(negedge clock);
    check_eq(dac_code, 16'h0000);
    host.load_pulse();
    check_eq(dac_code, code);
    // Framed mode: good word, bad stop, full-scale word
    host.set_framed(1'b1);
    check_eq(async_mode, 1'b1);
    // Mode entry shifted sixteen ones in; let the chain output's high run close
    exp = 16'hffff;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 3; k++) begin
      word = (k == 2) ? 16'hffff : rnd();
      p0 = pulses;
      host.frame(word, k != 1);
      if (k != 1) begin
        code = word;
      end
      check_eq(dac_code, code);
      check_eq(pulses - p0, k == 1);
    end
    check_eq(hi_len, 8);
    host.set_framed(1'b0);
    check_eq(async_mode, 1'b0);
    // Shift register was left alone by framed traffic
    load_word(rnd());
    // Modulator density against the latched code
    for (int j = 0; j < 3; j++) begin
      load_word(mod_codes[j]);
      ones = 0;
      repeat (64) @(negedge clock);
      repeat (1024) begin
        @(negedge clock);
        ones += int'(pdm_out === 1'b1);
      end
      check_eq(near(ones, code), 1'b1);
    end
    // Open-drain fault line with a shared pull-up
    repeat (8) begin
      loop_fault = rnd() > 16'h7fff;
      repeat (5) @(negedge clock);
      check_eq(fault_n_oe, loop_fault);
      check_eq(fault_n_oe ? fault_n_o : 1'b1, !loop_fault);
    end
    conclude();
  end
endmodule
